// *** rtl/mpf_pkg.sv ***
// mpf_pkg: constants, field layout and types of the metering pin function block
// assumes a single 125 MHz crystal-derived clock drives every user of it
package mpf_pkg;

  // clock and reset-pin low-time thresholds
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned T_LOCAL_MIN_NS = 10000000; // 10 ms
  localparam int unsigned T_CHIP_MIN_NS = 20000000; // 20 ms
  localparam int unsigned LOCAL_CYC = (T_LOCAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CHIP_CYC = (T_CHIP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 22;

  // fast transmitter bit time in clocks
  localparam logic [1:0] FAST_DIV_LAST = 2'h3; // four clocks per bit
  localparam logic [2:0] FAST_LAST_BIT = 3'h7;

  // register map
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h8;
  localparam logic [3:0] REG_STATE = 4'hC;

  // control register fields
  localparam int unsigned CTRL_PINSEL = 0;
  localparam int unsigned CTRL_SRC_LSB = 1;
  localparam int unsigned CTRL_TXM_LSB = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status and mask bits
  localparam int unsigned ST_W = 4;
  localparam int unsigned ST_LOCAL_RST = 0;
  localparam int unsigned ST_GLITCH = 1;
  localparam int unsigned ST_REVERSE_POWER_INDICATOR_RISE = 2;
  localparam int unsigned ST_FAST_DONE = 3;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // state register bits
  localparam int unsigned SR_RX = 0;
  localparam int unsigned SR_REVERSE_POWER_INDICATOR = 1;
  localparam int unsigned SR_BUSY = 2;
  localparam int unsigned SR_TXM_LSB = 3;

  // transmit pin source
  typedef enum logic [1:0] {
    TXM_UART = 2'b00,
    TXM_ZX = 2'b01,
    TXM_FAST = 2'b10
  } mpf_txmode_t;

  // second pulse pin power source
  typedef enum logic [1:0] {
    QS_REACTIVE = 2'b00,
    QS_ACT2 = 2'b01,
    QS_SUM = 2'b10,
    QS_USER = 2'b11
  } mpf_qsrc_t;

  // fast transmitter frame states
  typedef enum logic [1:0] {
    FT_IDLE = 2'b00,
    FT_START = 2'b01,
    FT_DATA = 2'b10,
    FT_STOP = 2'b11
  } mpf_ftx_t;

endpackage : mpf_pkg

// *** rtl/mpf_rst_if.sv ***
// mpf_rst_if: link between the top and the reset-pin low-time detector
// assumes both ends share one clock
`timescale 1ns/10ps
interface mpf_rst_if;
  logic rx_level;
  logic uart_reset;
  logic chip_reset;
  logic glitch;

  modport det (input rx_level, output uart_reset, output chip_reset, output glitch);
  modport ctl (output rx_level, input uart_reset, input chip_reset, input glitch);
endinterface : mpf_rst_if

// *** rtl/mpf_rst_det.sv ***
// mpf_rst_det: measures the low time of the shared receive/reset pin
// assumes rx_level is already synchronised to clk
`timescale 1ns/10ps
module mpf_rst_det #(
  parameter int unsigned LOCAL_CYC = mpf_pkg::LOCAL_CYC,
  parameter int unsigned CHIP_CYC = mpf_pkg::CHIP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // detector side of the link
  mpf_rst_if.det rif
);

  localparam logic [mpf_pkg::CNT_W-1:0] LOCAL_N = LOCAL_CYC[mpf_pkg::CNT_W-1:0];
  localparam logic [mpf_pkg::CNT_W-1:0] CHIP_N = CHIP_CYC[mpf_pkg::CNT_W-1:0];

  typedef struct packed {
    logic [mpf_pkg::CNT_W-1:0] cnt;
    logic chip;
    logic urst;
    logic glitch;
  } mpf_det_st_t;

  mpf_det_st_t s_r;
  mpf_det_st_t s_nxt;

  // low-time counter, independent of any receive logic
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.urst = 1'b0;
    s_nxt.glitch = 1'b0;
    if (!rif.rx_level)
    begin
      if (s_r.cnt != CHIP_N)
        s_nxt.cnt = s_r.cnt + 1'b1;
      else
        s_nxt.chip = 1'b1;
    end
    else
    begin
      // decide on the release edge
      if (!s_r.chip && s_r.cnt >= LOCAL_N)
        s_nxt.urst = 1'b1;
      else if (s_r.cnt != '0 && s_r.cnt < LOCAL_N)
        s_nxt.glitch = 1'b1;
      s_nxt.cnt = '0;
      s_nxt.chip = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // outputs straight from flip-flops
  assign rif.uart_reset = s_r.urst;
  assign rif.chip_reset = s_r.chip;
  assign rif.glitch = s_r.glitch;

endmodule : mpf_rst_det

// *** rtl/mpf_top.sv ***
// mpf_top: pin functions of the metering device: reset decode on the receive pin,
// second pulse pin select, transmit pin source and fast autonomous transmitter
// assumes all datapath and serial inputs are on CLK; RX_PIN is asynchronous
//
// Function
// - receive pin low 10..20 ms resets only the serial module
// - receive pin low beyond 20 ms resets the whole chip
// - reset decode runs apart from serial receive; chip reset acts like reset pin
// - second pulse pin gives pulses when select bit is 0, reverse power at 1
// - second pulse pin follows reactive, second active, vector sum or user power
// - active pulse pin idles low and follows active power pulses
// - special command switches transmit pin to live current zero-crossing square wave
// - fast transmitter sends at clock over four; receive side unchanged
`timescale 1ns/10ps
module mpf_top #(
  parameter int unsigned LOCAL_CYC = mpf_pkg::LOCAL_CYC,
  parameter int unsigned CHIP_CYC = mpf_pkg::CHIP_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  // device pins
  input wire logic RX_PIN,
  output logic TX_PIN,
  output logic PF_PIN,
  output logic QF_PIN,
  // metering datapath
  input wire logic ACTIVE_PULSE,
  input wire logic REACTIVE_PULSE,
  input wire logic ACT2_PULSE,
  input wire logic SUM_PULSE,
  input wire logic USER_PULSE,
  input wire logic REVERSE_POWER,
  input wire logic IA_ZX,
  // serial module
  output logic UART_RX,
  input wire logic UART_TX,
  input wire logic ZX_CMD,
  output logic UART_RESET,
  // fast transmitter stream
  input wire logic [7:0] FAST_DATA,
  input wire logic FAST_VALID,
  output logic FAST_READY,
  // chip reset request
  output logic CHIP_RESET_N
);

  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    logic pinsel;
    mpf_pkg::mpf_qsrc_t qsrc;
    mpf_pkg::mpf_txmode_t txmode;
    logic [3:0] status;
    logic [3:0] mask;
    logic [31:0] rdata;
    logic pf;
    logic qf;
    logic tx;
    logic reverse_power_indicator_d;
    mpf_pkg::mpf_ftx_t fstate;
    logic [1:0] div;
    logic [2:0] bitn;
    logic [7:0] shreg;
  } mpf_top_st_t;

  mpf_top_st_t s_r;
  mpf_top_st_t s_nxt;
  mpf_rst_if rif ();
  logic fast_take;
  logic fast_done;
  logic reverse_power_indicator_rise;
  logic q_pulse;
  logic [3:0] ev;
  logic [31:0] ctrl_view;
  logic [31:0] state_view;

  // reset-pin detector on the synchronised level
  assign rif.rx_level = s_r.rx_sync;

  mpf_rst_det #(
    .LOCAL_CYC(LOCAL_CYC),
    .CHIP_CYC(CHIP_CYC)
  ) u_det (
    .clk(CLK),
    .nrst(NRST),
    .rif(rif)
  );

  // stream handshake: a byte is taken only when idle in fast mode
  assign FAST_READY = (s_r.txmode == mpf_pkg::TXM_FAST)
    && (s_r.fstate == mpf_pkg::FT_IDLE);
  assign fast_take = FAST_READY && FAST_VALID;
  assign fast_done = (s_r.fstate == mpf_pkg::FT_STOP)
    && (s_r.div == mpf_pkg::FAST_DIV_LAST);

  // reverse power edge for the event flags
  assign reverse_power_indicator_rise = REVERSE_POWER && !s_r.reverse_power_indicator_d;

  // power source of the second pulse pin
  always_comb
  begin
    case (s_r.qsrc)
      mpf_pkg::QS_REACTIVE: q_pulse = REACTIVE_PULSE;
      mpf_pkg::QS_ACT2: q_pulse = ACT2_PULSE;
      mpf_pkg::QS_SUM: q_pulse = SUM_PULSE;
      mpf_pkg::QS_USER: q_pulse = USER_PULSE;
      default: q_pulse = REACTIVE_PULSE;
    endcase
  end

  // events that set sticky status bits
  always_comb
  begin
    ev = '0;
    ev[mpf_pkg::ST_LOCAL_RST] = rif.uart_reset;
    ev[mpf_pkg::ST_GLITCH] = rif.glitch;
    ev[mpf_pkg::ST_REVERSE_POWER_INDICATOR_RISE] = reverse_power_indicator_rise;
    ev[mpf_pkg::ST_FAST_DONE] = fast_done;
  end

  // read views of control and state
  always_comb
  begin
    ctrl_view = '0;
    ctrl_view[mpf_pkg::CTRL_PINSEL] = s_r.pinsel;
    ctrl_view[mpf_pkg::CTRL_SRC_LSB +: 2] = s_r.qsrc;
    ctrl_view[mpf_pkg::CTRL_TXM_LSB +: 2] = s_r.txmode;
    state_view = '0;
    state_view[mpf_pkg::SR_RX] = s_r.rx_sync;
    state_view[mpf_pkg::SR_REVERSE_POWER_INDICATOR] = s_r.reverse_power_indicator_d;
    state_view[mpf_pkg::SR_BUSY] = (s_r.fstate != mpf_pkg::FT_IDLE);
    state_view[mpf_pkg::SR_TXM_LSB +: 2] = s_r.txmode;
  end

  // next state of the whole block
  always_comb
  begin
    s_nxt = s_r;

    // two-stage synchroniser on the shared pin
    s_nxt.rx_meta = RX_PIN;
    s_nxt.rx_sync = s_r.rx_meta;
    s_nxt.reverse_power_indicator_d = REVERSE_POWER;

    // control register write
    if (WR && ADDR == mpf_pkg::REG_CTRL)
    begin
      s_nxt.pinsel = WDATA[mpf_pkg::CTRL_PINSEL];
      s_nxt.qsrc = mpf_pkg::mpf_qsrc_t'(WDATA[mpf_pkg::CTRL_SRC_LSB +: 2]);
      case (WDATA[mpf_pkg::CTRL_TXM_LSB +: 2])
        2'h0: s_nxt.txmode = mpf_pkg::TXM_UART;
        2'h1: s_nxt.txmode = mpf_pkg::TXM_ZX;
        2'h2: s_nxt.txmode = mpf_pkg::TXM_FAST;
        default: s_nxt.txmode = s_r.txmode;
      endcase
    end

    // special command from the serial module selects zero-crossing output
    if (ZX_CMD)
      s_nxt.txmode = mpf_pkg::TXM_ZX;

    // serial module reset puts the transmit pin back to normal use
    if (rif.uart_reset)
      s_nxt.txmode = mpf_pkg::TXM_UART;

    // mask register write
    if (WR && ADDR == mpf_pkg::REG_MASK)
      s_nxt.mask = WDATA[mpf_pkg::ST_W-1:0];

    // status: write one clears, a new event wins over the clear
    if (WR && ADDR == mpf_pkg::REG_STATUS)
      s_nxt.status = (s_r.status & ~WDATA[mpf_pkg::ST_W-1:0]) | ev;
    else
      s_nxt.status = s_r.status | ev;

    // fast transmitter: start, eight data bits lsb first, stop
    case (s_r.fstate)
      mpf_pkg::FT_IDLE:
      begin
        s_nxt.div = 2'h0;
        s_nxt.bitn = 3'h0;
        if (fast_take)
        begin
          s_nxt.shreg = FAST_DATA;
          s_nxt.fstate = mpf_pkg::FT_START;
        end
      end
      mpf_pkg::FT_START:
      begin
        s_nxt.div = s_r.div + 2'h1;
        if (s_r.div == mpf_pkg::FAST_DIV_LAST)
          s_nxt.fstate = mpf_pkg::FT_DATA;
      end
      mpf_pkg::FT_DATA:
      begin
        s_nxt.div = s_r.div + 2'h1;
        if (s_r.div == mpf_pkg::FAST_DIV_LAST)
        begin
          s_nxt.shreg = {1'b0, s_r.shreg[7:1]};
          s_nxt.bitn = s_r.bitn + 3'h1;
          if (s_r.bitn == mpf_pkg::FAST_LAST_BIT)
            s_nxt.fstate = mpf_pkg::FT_STOP;
        end
      end
      mpf_pkg::FT_STOP:
      begin
        s_nxt.div = s_r.div + 2'h1;
        if (s_r.div == mpf_pkg::FAST_DIV_LAST)
          s_nxt.fstate = mpf_pkg::FT_IDLE;
      end
      default:
      begin
        s_nxt.fstate = mpf_pkg::FT_IDLE;
      end
    endcase

    // transmit pin source
    case (s_r.txmode)
      mpf_pkg::TXM_UART: s_nxt.tx = UART_TX;
      mpf_pkg::TXM_ZX: s_nxt.tx = IA_ZX;
      mpf_pkg::TXM_FAST:
      begin
        case (s_r.fstate)
          mpf_pkg::FT_START: s_nxt.tx = 1'b0;
          mpf_pkg::FT_DATA: s_nxt.tx = s_r.shreg[0];
          default: s_nxt.tx = 1'b1;
        endcase
      end
      default: s_nxt.tx = 1'b1;
    endcase

    // pulse pins
    s_nxt.pf = ACTIVE_PULSE;
    s_nxt.qf = s_r.pinsel ? REVERSE_POWER : q_pulse;

    // register read, data in the next cycle, unmapped reads zero
    s_nxt.rdata = '0;
    if (RD)
    begin
      case (ADDR)
        mpf_pkg::REG_CTRL: s_nxt.rdata = ctrl_view;
        mpf_pkg::REG_STATUS: s_nxt.rdata = {28'h0000000, s_r.status};
        mpf_pkg::REG_MASK: s_nxt.rdata = {28'h0000000, s_r.mask};
        mpf_pkg::REG_STATE: s_nxt.rdata = state_view;
        default: s_nxt.rdata = '0;
      endcase
    end

    // chip reset from the pin clears everything but the pin path and the reverse power delay
    if (rif.chip_reset)
    begin
      s_nxt.pinsel = mpf_pkg::CTRL_RESET[mpf_pkg::CTRL_PINSEL];
      s_nxt.qsrc = mpf_pkg::QS_REACTIVE;
      s_nxt.txmode = mpf_pkg::TXM_UART;
      s_nxt.status = mpf_pkg::STATUS_RESET;
      s_nxt.mask = mpf_pkg::MASK_RESET;
      s_nxt.rdata = '0;
      s_nxt.pf = 1'b0;
      s_nxt.qf = 1'b0;
      s_nxt.tx = 1'b1;
      s_nxt.fstate = mpf_pkg::FT_IDLE;
      s_nxt.div = 2'h0;
      s_nxt.bitn = 3'h0;
      s_nxt.shreg = 8'h00;
    end
  end

  // state register, constants under reset
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      s_r <= '0;
      s_r.rx_meta <= 1'b1;
      s_r.rx_sync <= 1'b1;
      s_r.reverse_power_indicator_d <= 1'b0;
      s_r.tx <= 1'b1; // line idles high
      s_r.fstate <= mpf_pkg::FT_IDLE;
      s_r.qsrc <= mpf_pkg::QS_REACTIVE;
      s_r.txmode <= mpf_pkg::TXM_UART;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign RDATA = s_r.rdata;
  assign IRQ = |(s_r.status & s_r.mask);
  assign TX_PIN = s_r.tx;
  assign PF_PIN = s_r.pf;
  assign QF_PIN = s_r.qf;
  assign UART_RX = s_r.rx_sync;
  assign UART_RESET = rif.uart_reset;
  assign CHIP_RESET_N = !rif.chip_reset;

endmodule : mpf_top

// *** verification/mpf_top_properties.sv ***
// mpf_top_properties: port-level assertions for the metering pin function block
// assumes it is bound into mpf_top and sees its ports only
`timescale 1ns/10ps
module mpf_top_properties #(
  parameter int unsigned LOCAL_CYC = 20,
  parameter int unsigned CHIP_CYC = 40
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // register side
  input wire logic [31:0] RDATA,
  input wire logic IRQ,
  // pins and serial side
  input wire logic TX_PIN,
  input wire logic PF_PIN,
  input wire logic QF_PIN,
  input wire logic ACTIVE_PULSE,
  input wire logic UART_RX,
  input wire logic UART_RESET,
  input wire logic CHIP_RESET_N,
  // fast transmitter stream
  input wire logic [7:0] FAST_DATA,
  input wire logic FAST_VALID,
  input wire logic FAST_READY
);
  localparam int LO = LOCAL_CYC - 2;
  localparam int HI = CHIP_CYC + 2;
  localparam int LATE = CHIP_CYC + 6;
  int run_r;
  int last_r;
  logic [7:0] byte_r;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  // low-run length of the synced receive level, and the byte in flight
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      run_r <= 0;
      last_r <= 0;
      byte_r <= 8'h00;
    end
    else
    begin
      if (UART_RX)
        run_r <= 0;
      else if (run_r < 1000)
        run_r <= run_r + 1;
      if (UART_RX && run_r != 0)
        last_r <= run_r;
      if (FAST_VALID && FAST_READY)
        byte_r <= FAST_DATA;
    end
  end

  // serial-only reset: one pulse, only after a mid-length low
  chk_uart_single:
    assert property (UART_RESET |=> !UART_RESET) else $error("serial reset too long");
  chk_uart_window:
    assert property ($rose(UART_RESET) |-> last_r >= LO && last_r <= HI)
      else $error("serial reset after wrong low time");
  // chip reset: in time after a long low, held while low, clears the block
  chk_chip_late:
    assert property (run_r == LATE |-> !CHIP_RESET_N) else $error("chip reset missing");
  chk_chip_hold:
    assert property (!CHIP_RESET_N && !UART_RX |=> !CHIP_RESET_N)
      else $error("chip reset released early");
  chk_chip_clear:
    assert property (!CHIP_RESET_N |=> !PF_PIN && !QF_PIN && !IRQ && !FAST_READY
      && RDATA == 32'h0) else $error("chip reset left state");
  // active pulse pin copies the pulse one cycle late
  chk_pf_follow:
    assert property (CHIP_RESET_N |=> PF_PIN == $past(ACTIVE_PULSE))
      else $error("active pulse pin wrong");
  // fast frame: start bit of four clocks, then data lsb first
  chk_fast_start:
    assert property (FAST_VALID && FAST_READY |-> ##2 (!TX_PIN) [*4] ##1 TX_PIN == byte_r[0])
      else $error("fast frame start wrong");
  chk_fast_busy:
    assert property (FAST_VALID && FAST_READY |=> (!FAST_READY) [*8])
      else $error("fast ready during frame");

  cover property (UART_RESET);
  cover property ($fell(CHIP_RESET_N));
  cover property (FAST_VALID && FAST_READY);
endmodule : mpf_top_properties

bind mpf_top mpf_top_properties #(
  .LOCAL_CYC(LOCAL_CYC),
  .CHIP_CYC(CHIP_CYC)
) mpf_top_properties_inst (
  .CLK(CLK), .NRST(NRST), .RDATA(RDATA), .IRQ(IRQ), .TX_PIN(TX_PIN),
  .PF_PIN(PF_PIN), .QF_PIN(QF_PIN), .ACTIVE_PULSE(ACTIVE_PULSE), .UART_RX(UART_RX),
  .UART_RESET(UART_RESET), .CHIP_RESET_N(CHIP_RESET_N), .FAST_DATA(FAST_DATA),
  .FAST_VALID(FAST_VALID), .FAST_READY(FAST_READY)
);

// *** verification/mpf_host_model.sv ***
// mpf_host_model: host on the receive/reset and transmit pins
// assumes the fast transmitter sends four clocks a bit
`timescale 1ns/10ps
module mpf_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic rx_pin,
  input wire logic tx_pin
);
  initial rx_pin = 1'b1;

  // pull the receive pin low for n clocks
  task automatic hold_low(input int n);
    @(posedge clk);
    rx_pin <= 1'b0;
    repeat (n) @(posedge clk);
    rx_pin <= 1'b1;
  endtask : hold_low

  // take one frame, sampling each bit in its middle
  task automatic get_byte(output logic [7:0] b);
    int i;
    b = 8'h00;
    for (i = 0; i < 200 && tx_pin !== 1'b0; i++)
      @(posedge clk) #1;
    repeat (2) @(posedge clk);
    for (i = 0; i < 8; i++)
    begin
      repeat (4) @(posedge clk);
      #1 b[i] = tx_pin;
    end
  endtask : get_byte
endmodule : mpf_host_model

// *** verification/tb_metering_pin_function_and_reset_decode.sv ***
// tb: self-checking bench of the metering pin function block
// assumes short reset-pin thresholds on the design
`timescale 1ns/10ps
module tb_metering_pin_function_and_reset_decode;
  typedef struct packed {
    logic [4:0] ctrl;
    logic [7:0] ins;
    logic [2:0] exp;
  } mpf_row_t;
  localparam int LOC = 20;
  localparam int CHP = 40;
  // control, inputs {zx, uart tx, reverse, user, sum, act2, reactive, active}, {tx, qf, pf}
  mpf_row_t rows [11] = '{
    '{5'h00, 8'h42, 3'h6}, '{5'h02, 8'h04, 3'h2}, '{5'h04, 8'h09, 3'h3},
    '{5'h06, 8'h50, 3'h6}, '{5'h06, 8'h0E, 3'h0}, '{5'h01, 8'h02, 3'h0},
    '{5'h01, 8'h20, 3'h2}, '{5'h08, 8'h80, 3'h4}, '{5'h08, 8'h40, 3'h0},
    '{5'h19, 8'hA0, 3'h6}, '{5'h10, 8'h00, 3'h4}};
  logic CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, ZX_CMD = 1'b0, FAST_VALID = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0, RDATA, d;
  logic [7:0] ins = 8'h00, FAST_DATA = 8'h00, got;
  logic IRQ, RX_PIN, TX_PIN, PF_PIN, QF_PIN, UART_RX, UART_RESET, FAST_READY, CHIP_RESET_N;
  int fails = 0, checked = 0, nurst = 0, nchip = 0;

  mpf_top #(.LOCAL_CYC(LOC), .CHIP_CYC(CHP)) mpf_top_inst (
    .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .IRQ(IRQ), .RX_PIN(RX_PIN), .TX_PIN(TX_PIN), .PF_PIN(PF_PIN), .QF_PIN(QF_PIN),
    .ACTIVE_PULSE(ins[0]), .REACTIVE_PULSE(ins[1]), .ACT2_PULSE(ins[2]), .SUM_PULSE(ins[3]),
    .USER_PULSE(ins[4]), .REVERSE_POWER(ins[5]), .UART_TX(ins[6]), .IA_ZX(ins[7]),
    .UART_RX(UART_RX), .ZX_CMD(ZX_CMD), .UART_RESET(UART_RESET), .FAST_DATA(FAST_DATA),
    .FAST_VALID(FAST_VALID), .FAST_READY(FAST_READY), .CHIP_RESET_N(CHIP_RESET_N));
  mpf_host_model mpf_host_model_inst (.clk(CLK), .rx_pin(RX_PIN), .tx_pin(TX_PIN));

  // clock and event counters
  always #4 CLK = ~CLK;
  always @(posedge CLK)
  begin
    if (UART_RESET === 1'b1)
      nurst++;
    if (CHIP_RESET_N === 1'b0)
      nchip++;
  end

  // bus write and read, read data taken in the slot after the strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask : rd
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // watchdog
  initial
  begin
    repeat (5000) @(posedge CLK);
    fails++;
    finish_test();
  end

  // main sequence
  initial
  begin
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    #1 check("tx pf qf ready", {28'h0, TX_PIN, PF_PIN, QF_PIN, FAST_READY}, 32'h8);
    for (int a = 0; a < 4; a++)
    begin
      rd(a == 3 ? 4'h2 : 4'(a * 4), d);
      check("reset register", d, 32'h0);
    end
    // state view after reset: synced receive level high, nothing else
    rd(mpf_pkg::REG_STATE, d);
    check("reset state", d, 32'h1);
    @(posedge CLK);
    #1 check("rdata after slot", RDATA, 32'h0);
    check("serial rx idle", {31'h0, UART_RX}, 32'h1);
    foreach (rows[i])
    begin
      wr(mpf_pkg::REG_CTRL, {27'h0, rows[i].ctrl});
      ins <= rows[i].ins;
      repeat (2) @(posedge CLK);
      #1 check("tx qf pf", {29'h0, TX_PIN, QF_PIN, PF_PIN}, {29'h0, rows[i].exp});
    end
    // fast transmitter, two frames
    for (int k = 0; k < 2; k++)
    begin
      fork
        mpf_host_model_inst.get_byte(got);
        begin
          @(posedge CLK);
          FAST_DATA <= 8'hA5 ^ {8{k[0]}};
          FAST_VALID <= 1'b1;
          #1 check("fast ready", {31'h0, FAST_READY}, 32'h1);
          @(posedge CLK);
          FAST_VALID <= 1'b0;
        end
      join
      check("fast byte", {24'h0, got}, {24'h0, 8'hA5 ^ {8{k[0]}}});
      repeat (8) @(posedge CLK);
    end
    // sticky events, mask and clear
    ins <= 8'h00;
    rd(mpf_pkg::REG_STATUS, d);
    check("status", d, 32'hC);
    wr(mpf_pkg::REG_MASK, 32'h4);
    #1 check("irq set", {31'h0, IRQ}, 32'h1);
    wr(mpf_pkg::REG_STATUS, 32'hF);
    #1 check("irq clear", {31'h0, IRQ}, 32'h0);
    // zero-crossing command
    wr(mpf_pkg::REG_CTRL, 32'h0);
    ins <= 8'h80;
    ZX_CMD <= 1'b1;
    @(posedge CLK);
    ZX_CMD <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 check("zx on tx", {31'h0, TX_PIN}, 32'h1);
    // short, mid and long lows on the receive pin
    mpf_host_model_inst.hold_low(LOC / 2);
    repeat (6) @(posedge CLK);
    rd(mpf_pkg::REG_STATUS, d);
    check("short low", d, 32'h2);
    check("short resets", nurst, 0);
    wr(mpf_pkg::REG_STATUS, 32'h2);
    mpf_host_model_inst.hold_low(LOC + LOC / 2);
    repeat (6) @(posedge CLK);
    rd(mpf_pkg::REG_STATUS, d);
    check("mid low", d, 32'h1);
    check("mid resets", nurst + nchip, 1);
    check("tx back to serial", {31'h0, TX_PIN}, 32'h0);
    wr(mpf_pkg::REG_CTRL, 32'h1);
    mpf_host_model_inst.hold_low(CHP + CHP / 2);
    repeat (6) @(posedge CLK);
    check("chip reset", {31'h0, nchip > 0}, 32'h1);
    check("no serial reset", nurst, 1);
    rd(mpf_pkg::REG_CTRL, d);
    check("ctrl cleared", d, 32'h0);
    check("ready off in serial mode", {31'h0, FAST_READY}, 32'h0);
    finish_test();
  end
endmodule : tb_metering_pin_function_and_reset_decode
